// ===== logic/ssr_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none

module ssr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // Address width; the pointers carry one extra wrap bit above it to tell full from empty.
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // Storage words.
  logic [AW:0]      wr_ptr_r;      // Write pointer with wrap bit.
  logic [AW:0]      rd_ptr_r;      // Read pointer with wrap bit.
  logic             full;          // All words hold data.
  logic             empty;         // No word holds data.
  logic             push;          // A word enters this cycle.
  logic             pop;           // A word leaves this cycle.

  // Full when the pointers differ only in the wrap bit.
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  // Storage has no reset; only written words are ever read.
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  // Pointer update.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ===== logic/ssr_pkg.sv
// Shared constants and types for the sensor sample readout block.
package ssr_pkg;

  // Clock period of the block clock in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Interval between two periodic samples of every channel, in nanoseconds.
  localparam int unsigned SAMPLE_PERIOD_NS = 1_000_000;
  // Periodic sample interval as a count of clock cycles.
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Number of voltage and temperature channels.
  localparam int unsigned VOLT_CHANNELS = 7;
  localparam int unsigned TEMP_CHANNELS = 7;
  // Width of the request channel mask and of the channel index.
  localparam int unsigned MASK_W = 16;
  localparam int unsigned CHAN_W = 4;
  // Width of one converter code and of one stored temperature reading.
  localparam int unsigned VOLT_CODE_W = 8;
  localparam int unsigned TEMP_CODE_W = 16;
  // Result word width and its fraction widths.
  localparam int unsigned RESULT_W = 32;
  localparam int unsigned VOLT_FRAC_W = 16;
  localparam int unsigned TEMP_FRAC_W = 8;
  // Left shift that places an 8-bit code, one step of 1/128 V, into the result.
  localparam int unsigned VOLT_SHIFT = 9;
  // Depth of the result FIFO in beats.
  localparam int unsigned FIFO_DEPTH = 8;
  // Highest valid mask bit for temperature requests.
  localparam logic [CHAN_W-1:0] LAST_TEMP_CH = 4'h0006;
  // Highest mask bit index.
  localparam logic [CHAN_W-1:0] LAST_MASK_BIT = 4'h000F;

  // Kind of request: voltage or temperature.
  typedef enum logic { SSR_KIND_VOLT = 1'b0, SSR_KIND_TEMP = 1'b1 } ssr_kind_t;

  // Request as presented by the fabric.
  typedef struct packed {
    ssr_kind_t         kind;
    logic [MASK_W-1:0] mask;
  } ssr_cmd_t;

  // One result beat with its framing flags.
  typedef struct packed {
    logic [RESULT_W-1:0] data;
    logic [CHAN_W-1:0]   channel;
    logic                sop;
    logic                eop;
  } ssr_beat_t;

  // Controller states, one-hot.
  typedef enum logic [2:0] {
    SSR_ST_IDLE  = 3'b001,
    SSR_ST_SCAN  = 3'b010,
    SSR_ST_DRAIN = 3'b100
  } ssr_state_t;

endpackage

// ===== logic/ssr_readout.sv
// Sensor sample readout controller: periodic sample store and request streaming.
`timescale 1ns/1ns
`default_nettype none

module ssr_readout #(
  parameter int unsigned SAMPLE_CYCLES = ssr_pkg::SAMPLE_CYCLES
) (
  input  wire logic                                             clock,
  input  wire logic                                             srst,
  input  wire logic [ssr_pkg::VOLT_CHANNELS-1:0][ssr_pkg::VOLT_CODE_W-1:0] volt_code,
  input  wire logic [ssr_pkg::TEMP_CHANNELS-1:0][ssr_pkg::TEMP_CODE_W-1:0] temp_code,
  input  wire logic                                             cmd_valid,
  output logic                                                  cmd_ready,
  input  wire ssr_pkg::ssr_cmd_t                                cmd,
  output logic                                                  rsp_valid,
  input  wire logic                                             rsp_ready,
  output ssr_pkg::ssr_beat_t                                    rsp
);
  import ssr_pkg::*;

  // True when any mask bit above the given index is set.
  function automatic logic has_above(input logic [MASK_W-1:0] m, input logic [CHAN_W-1:0] i);
    logic [MASK_W-1:0] hi;
    hi = m >> i;
    return |(hi >> 1);
  endfunction

  logic [31:0]                                  tick_cnt_r;     // Sample interval counter.
  logic                                         sample_tick;    // One-cycle sample enable.
  logic [VOLT_CHANNELS-1:0][VOLT_CODE_W-1:0]    volt_store_r;   // Latest voltage codes.
  logic [TEMP_CHANNELS-1:0][TEMP_CODE_W-1:0]    temp_store_r;   // Latest temperature readings.
  ssr_state_t                                   state_r;        // Controller state.
  ssr_state_t                                   state_nxt;      // Next controller state.
  logic [MASK_W-1:0]                            mask_r;         // Mask of the request in work.
  ssr_kind_t                                    kind_r;         // Kind of the request in work.
  logic [CHAN_W-1:0]                            idx_r;          // Mask bit under inspection.
  logic                                         first_r;        // Next beat opens the packet.
  logic                                         accept;         // Request taken this cycle.
  logic [MASK_W-1:0]                            cmd_mask;       // Request mask, cut to its kind.
  logic                                         bit_set;        // Current mask bit is set.
  logic                                         is_last;        // No set bit above this one.
  logic [2:0]                                   ch;             // Store index of this bit.
  logic                                         ch_ok;          // Bit names an existing channel.
  logic [RESULT_W-1:0]                          volt_word;      // Scaled voltage result.
  logic [RESULT_W-1:0]                          temp_word;      // Sign-extended temperature.
  ssr_beat_t                                    beat;           // Beat offered to the FIFO.
  logic                                         push_valid;     // Beat offered this cycle.
  logic                                         push_ready;     // FIFO can take the beat.
  logic                                         push;           // Beat enters the FIFO.
  ssr_beat_t                                    fifo_beat;      // Beat at the FIFO head.
  logic                                         fifo_valid;     // FIFO holds a beat.
  logic                                         load_out;       // Output stage takes a beat.
  logic                                         last_taken;     // Final beat left the block.

  // The block only counts its own clock, so SAMPLE_PERIOD_NS holds only at the CLK_PERIOD_NS clock.
  assign sample_tick = (tick_cnt_r == SAMPLE_CYCLES - 1);

  // Sample interval divider.
  always_ff @(posedge clock)
  begin
    if (srst || sample_tick)
    begin
      tick_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // Periodic snapshot of every channel; requests read only these copies.
  generate
    for (genvar g = 0; g < VOLT_CHANNELS; g++)
    begin : g_store
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          volt_store_r[g] <= '0;
          temp_store_r[g] <= '0;
        end
        else if (sample_tick)
        begin
          volt_store_r[g] <= volt_code[g];
          temp_store_r[g] <= temp_code[g];
        end
      end
    end
  endgenerate

  // Request decode; temperature masks keep only the seven diode bits.
  assign accept   = cmd_valid && cmd_ready;
  assign cmd_mask = (cmd.kind == SSR_KIND_TEMP) ? {9'h000, cmd.mask[6:0]} : cmd.mask;
  assign bit_set  = mask_r[idx_r];
  assign is_last  = !has_above(mask_r, idx_r);
  assign ch       = idx_r[2:0];
  assign ch_ok    = (idx_r <= LAST_TEMP_CH);

  // Result formatting: unsigned Q16.16 volts, signed Q24.8 Celsius.
  assign volt_word = ch_ok ? (RESULT_W'(volt_store_r[ch]) << VOLT_SHIFT) : '0;
  assign temp_word = ch_ok ? {{(RESULT_W-TEMP_CODE_W){temp_store_r[ch][TEMP_CODE_W-1]}},
                              temp_store_r[ch]} : '0;

  assign beat.data    = (kind_r == SSR_KIND_TEMP) ? temp_word : volt_word;
  assign beat.channel = idx_r;
  assign beat.sop     = first_r;
  assign beat.eop     = is_last;
  assign push_valid   = state_r[1] && bit_set;
  assign push         = push_valid && push_ready;

  // Output stage: refill when empty or when the held beat is taken.
  assign load_out   = fifo_valid && (!rsp_valid || rsp_ready);
  assign last_taken = rsp_valid && rsp_ready && rsp.eop;

  // Next-state logic.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SSR_ST_IDLE:
      begin
        // An empty mask has no beats, so ready simply stays up.
        if (accept && (|cmd_mask))
        begin
          state_nxt = SSR_ST_SCAN;
        end
      end
      SSR_ST_SCAN:
      begin
        if (push && is_last)
        begin
          state_nxt = SSR_ST_DRAIN;
        end
      end
      SSR_ST_DRAIN:
      begin
        if (last_taken)
        begin
          state_nxt = SSR_ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = SSR_ST_IDLE;
      end
    endcase
  end

  // State and ready register; ready is high exactly in idle.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_r   <= SSR_ST_IDLE;
      cmd_ready <= 1'b1;
    end
    else
    begin
      state_r   <= state_nxt;
      cmd_ready <= (state_nxt == SSR_ST_IDLE);
    end
  end

  // Request capture and mask walk; a clear bit is skipped in one cycle.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      mask_r  <= '0;
      kind_r  <= SSR_KIND_VOLT;
      idx_r   <= '0;
      first_r <= 1'b0;
    end
    else if (accept)
    begin
      mask_r  <= cmd_mask;
      kind_r  <= cmd.kind;
      idx_r   <= '0;
      first_r <= 1'b1;
    end
    else if (state_r[1] && (!bit_set || push) && (idx_r != LAST_MASK_BIT))
    begin
      idx_r   <= idx_r + 4'h0001;
      first_r <= first_r && !push;
    end
  end

  // The FIFO lets the walk run ahead while the fabric stalls the response.
  ssr_fifo #(
    .WIDTH ($bits(ssr_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) ssr_fifo_inst (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (beat),
    .out_valid (fifo_valid),
    .out_ready (load_out),
    .out_data  (fifo_beat)
  );

  // Response registers hold a beat until the fabric takes it.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end
    else if (load_out)
    begin
      rsp_valid <= 1'b1;
      rsp       <= fifo_beat;
    end
    else if (rsp_ready)
    begin
      rsp_valid <= 1'b0;
    end
  end

  // Final beat handed to the fabric.
  sequence s_last_taken;
    rsp_valid && rsp_ready && rsp.eop;
  endsequence

  // A stalled beat that is held back.
  sequence s_stalled;
    rsp_valid && !rsp_ready;
  endsequence

  accept_drop_a: assert property (@(posedge clock) disable iff (srst)
    (accept && (|cmd_mask)) |=> !cmd_ready [*2])
    else $error("ready stayed high after a request was taken");

  volt_hold_a: assert property (@(posedge clock) disable iff (srst)
    !sample_tick |=> $stable(volt_store_r))
    else $error("voltage store changed outside a sample tick");

  temp_hold_a: assert property (@(posedge clock) disable iff (srst)
    !sample_tick |=> $stable(temp_store_r))
    else $error("temperature store changed outside a sample tick");

  volt_format_a: assert property (@(posedge clock) disable iff (srst)
    (push && kind_r == SSR_KIND_VOLT) |-> (beat.data[31:17] == 15'h0000 && beat.data[8:0] == 9'h000))
    else $error("voltage word outside the 8-bit scaled range");

  temp_sign_a: assert property (@(posedge clock) disable iff (srst)
    (push && kind_r == SSR_KIND_TEMP) |-> (beat.data[31:16] == {16{beat.data[15]}}))
    else $error("temperature word not sign extended");

  temp_chan_a: assert property (@(posedge clock) disable iff (srst)
    (push && kind_r == SSR_KIND_TEMP) |-> (beat.channel <= LAST_TEMP_CH))
    else $error("temperature beat carries a channel above six");

  // The first flag is judged against the mask itself: no set bit may lie below the beat.
  beat_mask_a: assert property (@(posedge clock) disable iff (srst)
    push |-> (mask_r[beat.channel] &&
              (beat.sop == ((mask_r & ((16'h0001 << beat.channel) - 16'h0001)) == 16'h0000))))
    else $error("beat framing disagrees with the request mask");

  stall_hold_a: assert property (@(posedge clock) disable iff (srst)
    s_stalled |=> (rsp_valid && $stable(rsp)))
    else $error("response beat changed while stalled");

  ready_back_a: assert property (@(posedge clock) disable iff (srst)
    s_last_taken |=> cmd_ready)
    else $error("ready did not return after the final beat");

endmodule

`default_nettype wire

// ===== tb/ssr_requester.sv
// Fabric-side requester model: issues one request and logs every beat it takes.
`timescale 1ns/1ns
`default_nettype none

module ssr_requester (
  input  wire logic               clock,
  input  wire logic               srst,
  input  wire logic               go,        // One-cycle pulse that starts a request.
  input  wire ssr_pkg::ssr_cmd_t  go_cmd,    // Request to present.
  input  wire logic               stall,     // Holds the response sink off.
  output logic                    cmd_valid,
  input  wire logic               cmd_ready,
  output ssr_pkg::ssr_cmd_t       cmd,
  input  wire logic               rsp_valid,
  output logic                    rsp_ready,
  input  wire ssr_pkg::ssr_beat_t rsp,
  output var int                  n_beats,   // Beats taken since the last request.
  output ssr_pkg::ssr_beat_t [15:0] log      // Beats in arrival order.
);
  import ssr_pkg::*;

  // The sink takes a beat in any cycle it is not told to stall.
  assign rsp_ready = !stall;

  // The request is held until the accepting edge, then scrambled so no stale value lingers.
  always @(posedge clock)
  begin
    if (srst)
    begin
      cmd_valid <= 1'b0;
      cmd       <= '0;
      n_beats   <= 0;
    end
    else
    begin
      if (go)
      begin
        cmd_valid <= 1'b1;
        cmd       <= go_cmd;
        n_beats   <= 0;
      end
      else if (cmd_valid && cmd_ready)
      begin
        cmd_valid <= 1'b0;
        cmd       <= ssr_cmd_t'(~cmd);
      end
      // A beat counts only on an edge where valid and ready are both high.
      if (rsp_valid && rsp_ready)
      begin
        log[n_beats[3:0]] <= rsp;
        n_beats           <= n_beats + 1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/tb_ssr_readout.sv
// Self-checking testbench for the sensor sample readout controller.
`timescale 1ns/1ns
`default_nettype none

module tb_ssr_readout;
  import ssr_pkg::*;

  // A long tick period leaves room to show that answers come from the stored snapshot.
  localparam int unsigned SC = 64;

  logic                                      clock;
  logic                                      srst;
  logic                                      go;
  logic                                      stall;
  logic                                      cmd_valid;
  logic                                      cmd_ready;
  logic                                      rsp_valid;
  logic                                      rsp_ready;
  ssr_cmd_t                                  go_cmd;
  ssr_cmd_t                                  cmd;
  ssr_beat_t                                 rsp;
  ssr_beat_t                                 held;
  ssr_beat_t [15:0]                          log_w;
  int                                        n_beats;
  int                                        n_fail = 0;
  int                                        samples_checked = 0;
  int                                        cycles = 0;
  logic [VOLT_CHANNELS-1:0][VOLT_CODE_W-1:0] vcode;
  logic [TEMP_CHANNELS-1:0][TEMP_CODE_W-1:0] tcode;

  ssr_readout #(.SAMPLE_CYCLES(SC)) ssr_readout_inst (
    .clock(clock), .srst(srst), .volt_code(vcode), .temp_code(tcode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp(rsp));

  ssr_requester ssr_requester_inst (
    .clock(clock), .srst(srst), .go(go), .go_cmd(go_cmd), .stall(stall),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp(rsp), .n_beats(n_beats), .log(log_w));

  // Free-running 10 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // A hang is cut short well past the expected run length.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Inputs always move one nanosecond after the rising edge.
  task automatic tick(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(logic ok, string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  // Expected result word for a channel, from the codes the bench applies.
  function automatic logic [31:0] expd(ssr_kind_t k, int ch);
    if (k == SSR_KIND_TEMP)
      return {{16{tcode[ch][15]}}, tcode[ch]};
    if (ch >= VOLT_CHANNELS)
      return 32'h0000_0000;
    return {15'h0000, vcode[ch], 9'h000};
  endfunction

  // Issues a request and checks that ready drops after a non-empty one.
  task automatic send(ssr_kind_t k, logic [15:0] m);
    int i;
    go_cmd = '{kind: k, mask: m};
    go = 1'b1;
    tick();
    go = 1'b0;
    i = 0;
    while (!(cmd_valid && cmd_ready) && i < 50)
    begin
      tick();
      i++;
    end
    tick(2);
    if (m != 16'h0000)
      check(cmd_ready === 1'b0, "ready still high after accept");
  endtask

  // Waits for all beats, then for ready to come back within three cycles.
  task automatic finish(int n);
    int i;
    i = 0;
    while (n_beats < n && i < 300)
    begin
      tick();
      i++;
    end
    i = 0;
    while (cmd_ready !== 1'b1 && i < 3)
    begin
      tick();
      i++;
    end
    check(cmd_ready === 1'b1, "ready not back after last beat");
    check(n_beats === n, "beat count");
  endtask

  // Beats must come in ascending channel order, framed first and last.
  task automatic verify(ssr_kind_t k, logic [15:0] m);
    int b;
    int lo;
    int hi;
    b = 0;
    lo = -1;
    hi = 0;
    for (int c = 0; c < 16; c++)
      if (m[c])
      begin
        if (lo < 0)
          lo = c;
        hi = c;
      end
    for (int c = 0; c < 16; c++)
      if (m[c])
      begin
        check(log_w[b].channel === 4'(c) && log_w[b].data === expd(k, c)
              && log_w[b].sop === (c == lo) && log_w[b].eop === (c == hi), "beat");
        b++;
      end
  endtask

  task automatic run(ssr_kind_t k, logic [15:0] m, int n);
    send(k, m);
    finish(n);
    verify(k, m);
  endtask

  // Every voltage channel, including full-scale and zero codes.
  task automatic t_volt;
    run(SSR_KIND_VOLT, 16'h007F, 7);
    run(SSR_KIND_VOLT, 16'h000B, 3);
  endtask

  // All diode channels together, then each one alone.
  task automatic t_temp;
    run(SSR_KIND_TEMP, 16'h007F, 7);
    check(log_w[1].data === 32'hFFFF_E1C0, "minus 30.25 C word");
    for (int c = 0; c < 7; c++)
      run(SSR_KIND_TEMP, 16'(1 << c), 1);
  endtask

  // An empty mask is taken with no beats and ready stays high.
  task automatic t_empty;
    send(SSR_KIND_VOLT, 16'h0000);
    tick(4);
    check(cmd_ready === 1'b1 && n_beats === 0 && rsp_valid === 1'b0, "empty");
  endtask

  // Stalling fills the buffer; the head beat must hold still until taken.
  task automatic t_fill;
    stall = 1'b1;
    send(SSR_KIND_VOLT, 16'hFFFF);
    tick(30);
    check(rsp_valid === 1'b1 && n_beats === 0 && cmd_ready === 1'b0, "stall");
    held = rsp;
    tick(5);
    check(rsp_valid === 1'b1 && rsp === held, "beat moved under stall");
    stall = 1'b0;
    tick(3);
    stall = 1'b1;
    tick(4);
    stall = 1'b0;
    finish(16);
    verify(SSR_KIND_VOLT, 16'hFFFF);
  endtask

  // Aligns to a tick, changes the input, and expects the stored value until the next tick.
  task automatic t_snap(ssr_kind_t k);
    logic [31:0] old;
    int          i;
    vcode[2] += 8'h11;
    tcode[2] += 16'h0111;
    i = 0;
    do
    begin
      send(k, 16'h0004);
      finish(1);
      i++;
    end
    while (log_w[0].data !== expd(k, 2) && i < 30);
    check(i < 30, "stored sample never refreshed");
    old = expd(k, 2);
    vcode[2] += 8'h11;
    tcode[2] += 16'h0111;
    send(k, 16'h0004);
    finish(1);
    check(log_w[0].data === old, "live value instead of stored");
  endtask

  // Reset, let one tick store the codes, then run every scenario.
  initial
  begin
    srst = 1'b1;
    go = 1'b0;
    stall = 1'b0;
    go_cmd = '0;
    for (int i = 0; i < 7; i++)
    begin
      vcode[i] = 8'h60 + 8'(i * 37);
      tcode[i] = i[0] ? 16'hE1C0 - 16'(i) : 16'h1A80 + 16'(i);
    end
    vcode[0] = 8'hFF;
    vcode[1] = 8'h00;
    tcode[1] = 16'hE1C0;
    repeat (16) @(posedge clock);
    #1;
    srst = 1'b0;
    check(cmd_ready === 1'b1 && rsp_valid === 1'b0, "idle after reset");
    tick(SC + 2);
    t_volt();
    t_temp();
    t_empty();
    t_fill();
    t_snap(SSR_KIND_VOLT);
    t_snap(SSR_KIND_TEMP);
    end_of_test();
  end
endmodule

`default_nettype wire
